// [shared/pxs_map.svh]
// offsets, field positions, reset values and timing counts of the status/control bank
`ifndef PXS_MAP_SVH
`define PXS_MAP_SVH

// register numbers on the management port
`define PXS_ADDR_STATUS 5'h1c
`define PXS_ADDR_CTRL 5'h1d

// status register fields
`define PXS_ST_MISSING_SFD 8
`define PXS_ST_CODE_VIOL 7
`define PXS_ST_POLARITY 6
`define PXS_ST_LINK_DROP 5
`define PXS_ST_UNLOCK 4
`define PXS_ST_FALSE_CARRIER 3
`define PXS_ST_FORCED_JAM 2
`define PXS_ST_FAST_UP 1
`define PXS_ST_SLOW_UP 0

// control register fields
`define PXS_CT_SOFT_RST 15
`define PXS_CT_TX_ON 12
`define PXS_CT_LED_FLASH 11
`define PXS_CT_RX_ONLY 10
`define PXS_CT_LINK_ERR 9
`define PXS_CT_UNLOCK_CODE 8
`define PXS_CT_STRETCH 7
`define PXS_CT_CODER_BYP 6
`define PXS_CT_ALIGN_BYP 5
`define PXS_CT_SCR_BYP 4
`define PXS_CT_CIM_EN 3
`define PXS_CT_JAM_EN 2

// reset value and writable bits (15 self clears, 1:0 live elsewhere)
`define PXS_CTRL_RESET 16'h1000
`define PXS_CTRL_WMASK 16'h7ffc

// error nibbles placed on the receive data lines
`define PXS_CODE_VIOL_NIB 4'h1
`define PXS_LINK_ERR_NIB 4'h2
`define PXS_PACKET_ERROR_CODE_ENABLE_NIB 4'h3

// stretch time: 42 ms least, clock 100 MHz
`define PXS_STRETCH_MS 42
`define PXS_CLK_KHZ 100000
`define PXS_STRETCH_CYC (`PXS_STRETCH_MS * `PXS_CLK_KHZ)

`endif

// [shared/pxs_pkg.sv]
// types shared by the status/control bank
package pxs_pkg;
    typedef logic [15:0] pxs_word_t;
    typedef logic [4:0] pxs_addr_t;
    typedef logic [3:0] pxs_nibble_t;
endpackage

// [src/pxs_regs.sv]
// status register 28 and fast-mode control register 29 with their pin effects
`timescale 1ns/1ns
`default_nettype none
`include "pxs_map.svh"

module pxs_regs #(
    parameter int STRETCH_CYCLES = `PXS_STRETCH_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    // management register port (from the management frame decoder)
    input wire pxs_pkg::pxs_addr_t mgmt_addr,
    input wire logic mgmt_write,
    input wire logic mgmt_read,
    input wire pxs_pkg::pxs_word_t mgmt_wdata,
    output pxs_pkg::pxs_word_t mgmt_rdata,
    output logic mgmt_rvalid,
    output logic management_soft_reset,
    // transceiver state, same clock
    input wire logic speed_100,
    input wire logic autopolarity_control,
    input wire logic sfd_missing_evt,
    input wire logic manchester_viol_evt,
    input wire logic polarity_reversed,
    input wire logic link_drop_evt,
    input wire logic scrambler_unlock_evt,
    input wire logic false_carrier_evt,
    input wire logic forced_jam_evt,
    input wire logic fast_xcvr_up,
    input wire logic slow_xcvr_up,
    // pins, asynchronous
    input wire logic led_flash_input,
    input wire logic carrier_receive_only_pin,
    input wire logic coder_bypass_pin,
    input wire logic scrambler_bypass_pin,
    input wire logic carrier_integrity_pin,
    // receive path toward the mii
    input wire pxs_pkg::pxs_nibble_t rx_nibble_in,
    input wire logic rx_error_in,
    input wire logic link_error_cond,
    input wire logic scrambler_unlocked,
    output pxs_pkg::pxs_nibble_t mii_receive_nibble,
    output logic mii_receive_error,
    // transmit pair
    input wire logic tx_pair_pos_in,
    input wire logic tx_pair_neg_in,
    output logic twisted_pair_out_pos,
    output logic twisted_pair_out_neg,
    // carrier sense and collision
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic col_or_crs_in,
    input wire logic cim_jam_cond,
    output logic mii_carrier_sense,
    output logic collision_or_carrier_out,
    // status led drivers: collision, transmit, receive
    input wire logic [2:0] led_status_in,
    output logic [2:0] led_status_out,
    // configuration levels to the coding stages
    output logic led_flash_enable,
    output logic coder_bypass,
    output logic aligner_bypass,
    output logic scrambler_bypass,
    output logic carrier_integrity_enable,
    output logic polarity_corrected_flag
);
    import pxs_pkg::*;

    pxs_word_t ctrl; // control register, bit 15 always stored as zero
    logic [8:2] flags; // latched status bits
    logic [6:0] next_flags_set; // events seen this cycle
    logic [4:0] pin_meta; // first synchroniser stage, read only by pin_sync
    logic [4:0] pin_sync; // pins after two flops
    logic wr_status; // write strobe to register 28 (read only, ignored)
    logic wr_ctrl; // write strobe to register 29
    logic rd_status; // read strobe to register 28
    logic soft_rst; // management reset request this cycle
    pxs_word_t status_word; // current value of register 28

    // decode of the register port
    // the address is decoded in the cycle of the strobe; nothing is pipelined
    assign wr_ctrl = mgmt_write && (mgmt_addr == `PXS_ADDR_CTRL);
    assign wr_status = mgmt_write && (mgmt_addr == `PXS_ADDR_STATUS);
    assign rd_status = mgmt_read && (mgmt_addr == `PXS_ADDR_STATUS);
    assign soft_rst = wr_ctrl && mgmt_wdata[`PXS_CT_SOFT_RST];

    // two-flop synchroniser for the strap and control pins; the pins are
    // asynchronous, so no logic may read them before the second flop, at the
    // price of three cycles before an output follows a pin change
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_meta <= {carrier_integrity_pin, scrambler_bypass_pin,
                coder_bypass_pin, carrier_receive_only_pin, led_flash_input};
            pin_sync <= pin_meta;
        end
    end

    // control register: write, self-clearing reset, defaults
    // bit 15 is never stored, so a read always shows the reset bit cleared
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `PXS_CTRL_RESET;
        end else if (soft_rst) begin
            // restore defaults, bit reads back zero
            ctrl <= `PXS_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= mgmt_wdata & `PXS_CTRL_WMASK;
        end
    end

    // event qualification by speed: each flag is only meaningful in one mode
    // an event in the wrong mode is dropped here rather than stored and masked
    always_comb begin
        next_flags_set = 7'h00;
        next_flags_set[`PXS_ST_MISSING_SFD - 2] = sfd_missing_evt && !speed_100;
        next_flags_set[`PXS_ST_CODE_VIOL - 2] = manchester_viol_evt && !speed_100;
        next_flags_set[`PXS_ST_LINK_DROP - 2] = link_drop_evt && speed_100;
        next_flags_set[`PXS_ST_UNLOCK - 2] = scrambler_unlock_evt && speed_100;
        next_flags_set[`PXS_ST_FALSE_CARRIER - 2] = false_carrier_evt && speed_100;
        next_flags_set[`PXS_ST_FORCED_JAM - 2] = forced_jam_evt && speed_100;
    end

    // latched-high flags; bit 6 is live and kept out of the latch
    // a management reset drops events of its own cycle; it is a reset, not a read
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= 7'h00;
        end else if (soft_rst) begin
            // management reset clears the latched status flags as well; bits 6, 1 and 0 stay live
            flags <= 7'h00;
        end else if (rd_status) begin
            // clear what was read, new events win
            flags <= next_flags_set;
        end else begin
            flags <= flags | next_flags_set;
        end
    end

    // autopolarity_control low means the correction runs; the bit is live
    // polarity bit live, 10M with autopolarity on
    assign polarity_corrected_flag = polarity_reversed && !speed_100 && !autopolarity_control;

    // assemble register 28
    always_comb begin
        status_word = 16'h0000;
        status_word[`PXS_ST_MISSING_SFD] = flags[`PXS_ST_MISSING_SFD];
        status_word[`PXS_ST_CODE_VIOL] = flags[`PXS_ST_CODE_VIOL];
        status_word[`PXS_ST_POLARITY] = polarity_corrected_flag;
        status_word[`PXS_ST_LINK_DROP] = flags[`PXS_ST_LINK_DROP];
        status_word[`PXS_ST_UNLOCK] = flags[`PXS_ST_UNLOCK];
        status_word[`PXS_ST_FALSE_CARRIER] = flags[`PXS_ST_FALSE_CARRIER];
        status_word[`PXS_ST_FORCED_JAM] = flags[`PXS_ST_FORCED_JAM];
        status_word[`PXS_ST_FAST_UP] = fast_xcvr_up;
        status_word[`PXS_ST_SLOW_UP] = slow_xcvr_up;
    end

    // read data: registered, one cycle after the read strobe
    // the data stays until the next read, so a slow host may pick it up late
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_read;
            if (mgmt_read) begin
                case (mgmt_addr)
                    `PXS_ADDR_STATUS: mgmt_rdata <= status_word;
                    `PXS_ADDR_CTRL: mgmt_rdata <= ctrl;
                    // other register numbers are answered elsewhere
                    default: mgmt_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // soft reset pulse toward the lower sixteen registers
    // registered so the pulse is glitch free even though the decode is not
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            management_soft_reset <= 1'b0;
        end else begin
            management_soft_reset <= soft_rst;
        end
    end

    // receive nibble and error with substituted error codes
    // the code violation comes first because no control bit switches it off;
    // every path has the same one cycle delay so data and codes never reorder
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mii_receive_nibble <= 4'h0;
            mii_receive_error <= 1'b0;
        end else if (manchester_viol_evt && !speed_100) begin
            mii_receive_nibble <= `PXS_CODE_VIOL_NIB;
            mii_receive_error <= 1'b1;
        end else if (rx_error_in && ctrl[`PXS_CT_LINK_ERR] && link_error_cond) begin
            mii_receive_nibble <= `PXS_LINK_ERR_NIB;
            mii_receive_error <= 1'b1;
        end else if (rx_error_in && ctrl[`PXS_CT_UNLOCK_CODE] && scrambler_unlocked) begin
            mii_receive_nibble <= `PXS_PACKET_ERROR_CODE_ENABLE_NIB;
            mii_receive_error <= 1'b1;
        end else begin
            // plain pass-through, one cycle of latency on every path
            mii_receive_nibble <= rx_nibble_in;
            mii_receive_error <= rx_error_in;
        end
    end

    // transmit pair: forced idle levels when the transmitter is off
    // the reset levels equal the forced idle levels, so the pair cannot glitch
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            twisted_pair_out_pos <= 1'b0;
            twisted_pair_out_neg <= 1'b1;
        end else if (!ctrl[`PXS_CT_TX_ON]) begin
            twisted_pair_out_pos <= 1'b0;
            twisted_pair_out_neg <= 1'b1;
        end else begin
            twisted_pair_out_pos <= tx_pair_pos_in;
            twisted_pair_out_neg <= tx_pair_neg_in;
        end
    end

    // carrier sense and combined collision output
    // the select pin comes through the synchroniser and acts three cycles late
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mii_carrier_sense <= 1'b0;
            collision_or_carrier_out <= 1'b0;
        end else begin
            // receive only, or receive or transmit
            if (ctrl[`PXS_CT_RX_ONLY] || pin_sync[1]) begin
                mii_carrier_sense <= rx_active;
            end else begin
                mii_carrier_sense <= rx_active || tx_active;
            end
            collision_or_carrier_out <= col_or_crs_in ||
                (ctrl[`PXS_CT_JAM_EN] && cim_jam_cond);
        end
    end

    // configuration levels: register bit ored with the synchronised pin
    // the aligner bypass has no pin and follows the register bit alone
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            led_flash_enable <= 1'b0;
            coder_bypass <= 1'b0;
            aligner_bypass <= 1'b0;
            scrambler_bypass <= 1'b0;
            carrier_integrity_enable <= 1'b0;
        end else begin
            led_flash_enable <= ctrl[`PXS_CT_LED_FLASH] || pin_sync[0];
            coder_bypass <= ctrl[`PXS_CT_CODER_BYP] || pin_sync[2];
            aligner_bypass <= ctrl[`PXS_CT_ALIGN_BYP];
            scrambler_bypass <= ctrl[`PXS_CT_SCR_BYP] || pin_sync[3];
            carrier_integrity_enable <= ctrl[`PXS_CT_CIM_EN] || pin_sync[4];
        end
    end

    // pulse stretchers for the collision, transmit and receive led lines;
    // each line is held for at least STRETCH_CYCLES after its last high
    // cycle, so it lands inside the 42-84 ms window at the nominal clock
    // one stretcher per status line
    for (genvar i = 0; i < 3; i++) begin : g_stretch
        pxs_stretch #(
            .HOLD_CYCLES(STRETCH_CYCLES)
        ) u_stretch (
            .clock(clock),
            .sys_rst(sys_rst),
            .stretch_on(ctrl[`PXS_CT_STRETCH]),
            .line_in(led_status_in[i]),
            .line_out(led_status_out[i])
        );
    end

    // writes to the status register have no effect
    logic unused_ok;
    assign unused_ok = wr_status;
endmodule

// one stretched status line: the counter reloads while the input is high
// and counts down after it falls; a 32-bit count covers any sensible clock
module pxs_stretch #(
    parameter int HOLD_CYCLES = `PXS_STRETCH_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic stretch_on, // feature enable from the control register
    input wire logic line_in, // raw status line
    output logic line_out // stretched status line
);
    import pxs_pkg::*;

    logic [31:0] hold_cnt; // cycles still to hold after the input fell

    // counter: idle while the feature is off, reload on input, count down
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt <= 32'h0000_0000;
        end else if (!stretch_on) begin
            // feature off: no residue when it is switched on again
            hold_cnt <= 32'h0000_0000;
        end else if (line_in) begin
            hold_cnt <= 32'(HOLD_CYCLES);
        end else if (hold_cnt != 32'h0000_0000) begin
            // count down to zero and stop there
            hold_cnt <= hold_cnt - 32'h0000_0001;
        end
    end

    // output: high with the input or while the count runs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            line_out <= 1'b0;
        end else begin
            line_out <= line_in || (stretch_on && hold_cnt != 32'h0000_0000);
        end
    end
endmodule
`default_nettype wire

// [bench/pxs_mgmt_host.sv]
// management host model driving the register port of the status/control bank
`timescale 1ns/1ns
`default_nettype none
module pxs_mgmt_host (
    input wire logic clock,
    output pxs_pkg::pxs_addr_t mgmt_addr,
    output logic mgmt_write,
    output logic mgmt_read,
    output pxs_pkg::pxs_word_t mgmt_wdata,
    input wire pxs_pkg::pxs_word_t mgmt_rdata,
    input wire logic mgmt_rvalid
);
    import pxs_pkg::*;
    // idle port at time zero
    initial begin
        {mgmt_write, mgmt_read} = 2'b00;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // one write pulse; released data shows its inverse, not a stale copy
    task automatic wr(input pxs_addr_t a, input pxs_word_t d);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_write = 1'b1;
        @(negedge clock);
        mgmt_write = 1'b0;
        mgmt_wdata = ~d;
        // idle cycle so a following pulse never re-drives in the same step
        @(negedge clock);
    endtask
    // one read pulse; the answer stands from the taking edge and is sampled half a cycle later
    task automatic rd(input pxs_addr_t a, output pxs_word_t d, output logic ok);
        mgmt_addr = a;
        mgmt_read = 1'b1;
        @(negedge clock);
        mgmt_read = 1'b0;
        ok = mgmt_rvalid;
        d = mgmt_rdata;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// [bench/pxs_regs_sva.sv]
// port level assertions for the status/control bank
`timescale 1ns/1ns
`default_nettype none
`include "pxs_map.svh"
module pxs_regs_sva #(
    parameter int STRETCH_CYCLES = `PXS_STRETCH_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire pxs_pkg::pxs_addr_t mgmt_addr,
    input wire logic mgmt_write,
    input wire logic mgmt_read,
    input wire pxs_pkg::pxs_word_t mgmt_wdata,
    input wire pxs_pkg::pxs_word_t mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic management_soft_reset,
    input wire logic speed_100,
    input wire logic autopolarity_control,
    input wire logic polarity_reversed,
    input wire logic manchester_viol_evt,
    input wire logic polarity_corrected_flag,
    input wire logic twisted_pair_out_pos,
    input wire logic twisted_pair_out_neg,
    input wire logic aligner_bypass,
    input wire logic led_flash_input,
    input wire logic led_flash_enable,
    input wire pxs_pkg::pxs_nibble_t mii_receive_nibble,
    input wire logic mii_receive_error
);
    import pxs_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_RVALID: assert property (mgmt_rvalid == $past(mgmt_read))
        else $error("read answer not one cycle after request");
    AST_HI_ZERO: assert property (mgmt_rvalid && $past(mgmt_addr) == `PXS_ADDR_STATUS
        |-> mgmt_rdata[15:9] == 7'h00) else $error("status upper bits not zero");
    AST_POL: assert property (polarity_corrected_flag ==
        (polarity_reversed && !speed_100 && !autopolarity_control))
        else $error("polarity flag wrong");
    AST_TX_OFF: assert property (mgmt_write && mgmt_addr == `PXS_ADDR_CTRL
        && !mgmt_wdata[15] && !mgmt_wdata[12] |-> ##[1:2] (!twisted_pair_out_pos
        && twisted_pair_out_neg)) else $error("pair not forced idle");
    AST_ALIGN: assert property (mgmt_write && mgmt_addr == `PXS_ADDR_CTRL
        && !mgmt_wdata[15] && mgmt_wdata[5] |-> ##[1:2] aligner_bypass)
        else $error("aligner bypass not set");
    AST_SOFT: assert property (mgmt_write && mgmt_addr == `PXS_ADDR_CTRL
        && mgmt_wdata[15] |=> management_soft_reset) else $error("no soft reset pulse");
    AST_RXNIB: assert property (manchester_viol_evt && !speed_100 |=>
        mii_receive_nibble == `PXS_CODE_VIOL_NIB && mii_receive_error)
        else $error("violation code missing");
    AST_FLASH: assert property (led_flash_input [*5] |-> led_flash_enable)
        else $error("flash input not passed");
endmodule
`default_nettype wire

// [bench/pxs_regs_tb.sv]
// self-checking bench for the status/control bank
`timescale 1ns/1ns
`default_nettype none
`include "pxs_map.svh"
module pxs_regs_tb;
    import pxs_pkg::*;
    localparam int STRETCH = 8; // short stretch keeps the run brief
    logic clock, sys_rst, speed_100, autopolarity_control, polarity_reversed;
    logic sfd_missing_evt, manchester_viol_evt, link_drop_evt, scrambler_unlock_evt;
    logic false_carrier_evt, forced_jam_evt, fast_xcvr_up, slow_xcvr_up;
    logic led_flash_input, carrier_receive_only_pin, coder_bypass_pin;
    logic scrambler_bypass_pin, carrier_integrity_pin, rx_error_in, link_error_cond;
    logic scrambler_unlocked, tx_pair_pos_in, tx_pair_neg_in, rx_active, tx_active;
    logic col_or_crs_in, cim_jam_cond, mgmt_write, mgmt_read, mgmt_rvalid;
    logic management_soft_reset, mii_receive_error, twisted_pair_out_pos;
    logic twisted_pair_out_neg, mii_carrier_sense, collision_or_carrier_out;
    logic led_flash_enable, coder_bypass, aligner_bypass, scrambler_bypass;
    logic carrier_integrity_enable, polarity_corrected_flag;
    logic [2:0] led_status_in, led_status_out;
    pxs_addr_t mgmt_addr;
    pxs_word_t mgmt_wdata, mgmt_rdata;
    pxs_nibble_t rx_nibble_in, mii_receive_nibble;
    int mismatches, n_tests;
    pxs_regs #(.STRETCH_CYCLES(STRETCH)) u_dut (.*);
    pxs_mgmt_host u_host (.*);
    // free running 100 MHz clock
    always #5 clock = ~clock;
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input pxs_word_t got, input pxs_word_t exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read through the host and compare the answer
    task automatic rdc(input pxs_addr_t a, input pxs_word_t exp);
        pxs_word_t d;
        logic ok;
        u_host.rd(a, d, ok);
        chk(16'(ok), 16'h0001);
        chk(d, exp);
    endtask
    // flash, coder, aligner, scrambler, integrity levels as one word
    function automatic pxs_word_t cfg();
        return 16'({led_flash_enable, coder_bypass, aligner_bypass, scrambler_bypass,
            carrier_integrity_enable});
    endfunction
    task automatic t_map();
        rdc(`PXS_ADDR_CTRL, 16'h1000);
        u_host.wr(`PXS_ADDR_STATUS, 16'hffff);
        rdc(`PXS_ADDR_STATUS, 16'h0000);
        rdc(5'h05, 16'h0000);
    endtask
    // slow mode events; the link drop must be ignored here
    task automatic t_lat10();
        {polarity_reversed, link_drop_evt, sfd_missing_evt, manchester_viol_evt} = 4'hf;
        step(1);
        {link_drop_evt, sfd_missing_evt, manchester_viol_evt} = 3'h0;
        step(3);
        rdc(`PXS_ADDR_STATUS, 16'h01c0);
        autopolarity_control = 1'b1;
        rdc(`PXS_ADDR_STATUS, 16'h0000);
        // an event in the read cycle must survive into the next read
        {autopolarity_control, polarity_reversed, sfd_missing_evt} = 3'b001;
        rdc(`PXS_ADDR_STATUS, 16'h0000);
        sfd_missing_evt = 1'b0;
        rdc(`PXS_ADDR_STATUS, 16'h0100);
        rdc(`PXS_ADDR_STATUS, 16'h0000);
    endtask
    // fast mode events; polarity and delimiter must be ignored here
    task automatic t_lat100();
        speed_100 = 1'b1;
        {fast_xcvr_up, slow_xcvr_up, polarity_reversed} = 3'b111;
        {link_drop_evt, scrambler_unlock_evt, false_carrier_evt, forced_jam_evt,
            sfd_missing_evt} = 5'h1f;
        step(1);
        {link_drop_evt, scrambler_unlock_evt, false_carrier_evt, forced_jam_evt,
            sfd_missing_evt} = 5'h00;
        rdc(`PXS_ADDR_STATUS, 16'h003f);
        rdc(`PXS_ADDR_STATUS, 16'h0003);
        {fast_xcvr_up, slow_xcvr_up, polarity_reversed, speed_100} = 4'h0;
    endtask
    task automatic t_cfg();
        tx_pair_pos_in = 1'b1;
        u_host.wr(`PXS_ADDR_CTRL, 16'h7fff);
        step(1);
        chk(cfg(), 16'h001f);
        rdc(`PXS_ADDR_CTRL, 16'h7ffc);
        u_host.wr(`PXS_ADDR_CTRL, 16'h0000);
        step(1);
        chk(cfg(), 16'h0000);
        chk(16'({twisted_pair_out_pos, twisted_pair_out_neg}), 16'h0001);
        {led_flash_input, coder_bypass_pin, scrambler_bypass_pin, carrier_integrity_pin} = 4'hf;
        step(5);
        chk(cfg(), 16'h001b);
        {led_flash_input, coder_bypass_pin, scrambler_bypass_pin, carrier_integrity_pin} = 4'h0;
        u_host.wr(`PXS_ADDR_CTRL, 16'h1000);
        step(1);
        chk(16'({twisted_pair_out_pos, twisted_pair_out_neg}), 16'h0002);
    endtask
    task automatic t_rx();
        rx_nibble_in = 4'ha;
        {rx_error_in, link_error_cond} = 2'b11;
        u_host.wr(`PXS_ADDR_CTRL, 16'h1200);
        step(1);
        chk(16'({mii_receive_error, mii_receive_nibble}), 16'h0012);
        {link_error_cond, scrambler_unlocked} = 2'b01;
        u_host.wr(`PXS_ADDR_CTRL, 16'h1100);
        step(1);
        chk(16'({mii_receive_error, mii_receive_nibble}), 16'h0013);
        u_host.wr(`PXS_ADDR_CTRL, 16'h1000);
        step(1);
        chk(16'({mii_receive_error, mii_receive_nibble}), 16'h001a);
        {rx_error_in, scrambler_unlocked} = 2'b00;
    endtask
    // transmit only activity against the carrier select, plus the jam path
    task automatic t_crs();
        {tx_active, cim_jam_cond} = 2'b11;
        u_host.wr(`PXS_ADDR_CTRL, 16'h140c);
        step(1);
        chk(16'(mii_carrier_sense), 16'h0000);
        chk(16'(collision_or_carrier_out), 16'h0001);
        u_host.wr(`PXS_ADDR_CTRL, 16'h1000);
        step(1);
        chk(16'(mii_carrier_sense), 16'h0001);
        chk(16'(collision_or_carrier_out), 16'h0000);
        carrier_receive_only_pin = 1'b1;
        step(5);
        chk(16'(mii_carrier_sense), 16'h0000);
        {tx_active, cim_jam_cond, carrier_receive_only_pin} = 3'b000;
    endtask
    // one cycle status pulse, stretched and then plain
    task automatic t_str();
        u_host.wr(`PXS_ADDR_CTRL, 16'h1080);
        led_status_in = 3'h7;
        step(1);
        led_status_in = 3'h0;
        chk(16'(led_status_out), 16'h0007);
        step(STRETCH - 2);
        chk(16'(led_status_out), 16'h0007);
        step(8);
        chk(16'(led_status_out), 16'h0000);
        u_host.wr(`PXS_ADDR_CTRL, 16'h1000);
        led_status_in = 3'h7;
        step(1);
        led_status_in = 3'h0;
        step(2);
        chk(16'(led_status_out), 16'h0000);
    endtask
    task automatic t_soft();
        u_host.wr(`PXS_ADDR_CTRL, 16'h7ffc);
        sfd_missing_evt = 1'b1;
        step(1);
        sfd_missing_evt = 1'b0;
        u_host.wr(`PXS_ADDR_CTRL, 16'h8000);
        rdc(`PXS_ADDR_CTRL, 16'h1000);
        rdc(`PXS_ADDR_STATUS, 16'h0000);
        // mid-run reset: transmitter must come back on
        u_host.wr(`PXS_ADDR_CTRL, 16'h0000);
        sys_rst = 1'b1;
        step(1);
        sys_rst = 1'b0;
        rdc(`PXS_ADDR_CTRL, 16'h1000);
        chk(16'({twisted_pair_out_pos, twisted_pair_out_neg}), 16'h0002);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // reset for three cycles, then every scenario in turn
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {speed_100, autopolarity_control, polarity_reversed, sfd_missing_evt,
            manchester_viol_evt, link_drop_evt, scrambler_unlock_evt, false_carrier_evt,
            forced_jam_evt, fast_xcvr_up, slow_xcvr_up, led_flash_input,
            carrier_receive_only_pin, coder_bypass_pin, scrambler_bypass_pin,
            carrier_integrity_pin, rx_error_in, link_error_cond, scrambler_unlocked,
            tx_pair_pos_in, tx_pair_neg_in, rx_active, tx_active, col_or_crs_in,
            cim_jam_cond, led_status_in, rx_nibble_in} = '0;
        mismatches = 0;
        n_tests = 0;
        step(3);
        sys_rst = 1'b0;
        t_map();
        t_lat10();
        t_lat100();
        t_cfg();
        t_rx();
        t_crs();
        t_str();
        t_soft();
        finish_test();
    end
endmodule
bind pxs_regs pxs_regs_sva #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_sva (.*);
`default_nettype wire
